// file: src/iub_pkg.sv
// ==========================================================
// Shared constants for the bridge
package iub_pkg;

  // ========================================================
  // Buffer geometry
  localparam int unsigned FIFO_DEPTH = 512;
  localparam int unsigned PTR_W = 9;
  localparam int unsigned CNT_W = 10;
  localparam logic [CNT_W-1:0] FIFO_FULL = 10'h200;
  localparam logic [CNT_W-1:0] FIFO_EMPTY = 10'h000;

  // ========================================================
  // Serial protocol constants
  localparam logic [7:0] GC_ADDR = 8'h00;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h06;
  localparam logic [7:0] CMD_DATA_AVAIL = 8'h0C;
  localparam logic [7:0] CMD_FLUSH = 8'h0E;
  localparam logic [7:0] CMD_USB_STATE = 8'h16;
  localparam logic [7:0] CNT_SAT = 8'hFF;
  localparam logic [7:0] IDLE_BYTE = 8'hFF;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_BYTE = 4'h8;
  localparam logic [3:0] BIT_ZERO = 4'h0;

  // ========================================================
  // Configurable pin functions
  localparam logic [1:0] PF_OTHER = 2'h0;
  localparam logic [1:0] PF_CHG_HI = 2'h1;
  localparam logic [1:0] PF_CHG_LO = 2'h2;

  // ========================================================
  // Latency timer
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned LAT_TIME_US = 16000;
  localparam int unsigned LAT_CYCLES = LAT_TIME_US * CLK_MHZ;
  localparam int unsigned LAT_W = 21;

  // ========================================================
  // Types
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_AACK, ST_RX, ST_RACK, ST_TX, ST_TACK} iub_st_t;
  typedef enum logic [1:0] {RP_DATA, RP_COUNT, RP_STATE} iub_reply_t;

  // Byte count, saturating at the largest one-byte value
  function automatic logic [7:0] iub_sat8(input logic [CNT_W-1:0] c);
    iub_sat8 = (c > {2'h0, CNT_SAT}) ? CNT_SAT : c[7:0];
  endfunction : iub_sat8

endpackage : iub_pkg

// file: src/iub_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Byte stream with valid and ready
interface iub_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : iub_stream_if
`default_nettype wire

// file: src/iub_skid_buf.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Two-entry buffer: output stage plus one skid entry
module iub_skid_buf
  import iub_pkg::*;
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Streams
  iub_stream_if.snk in_s,
  iub_stream_if.src out_s
);

  logic out_v_r, out_v_nxt, skid_v_r, skid_v_nxt;
  logic [7:0] out_d_r, out_d_nxt, skid_d_r, skid_d_nxt;
  logic take;

  // Ready is a flop, so a receiver stall costs one word of skid
  assign in_s.ready = ~skid_v_r;
  assign out_s.valid = out_v_r;
  assign out_s.data = out_d_r;
  assign take = in_s.valid & ~skid_v_r;

  // Next values
  always_comb
  begin
    out_v_nxt = out_v_r;
    out_d_nxt = out_d_r;
    skid_v_nxt = skid_v_r;
    skid_d_nxt = skid_d_r;
    if (out_s.ready | ~out_v_r)
    begin
      if (skid_v_r)
      begin
        out_v_nxt = 1'b1;
        out_d_nxt = skid_d_r;
        skid_v_nxt = 1'b0;
      end
      else
      begin
        out_v_nxt = take;
        out_d_nxt = in_s.data;
      end
    end
    else if (take)
    begin
      skid_v_nxt = 1'b1;
      skid_d_nxt = in_s.data;
    end
  end

  // Registers
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      out_v_r <= 1'b0;
      out_d_r <= 8'h00;
      skid_v_r <= 1'b0;
      skid_d_r <= 8'h00;
    end
    else
    begin
      out_v_r <= out_v_nxt;
      out_d_r <= out_d_nxt;
      skid_v_r <= skid_v_nxt;
      skid_d_r <= skid_d_nxt;
    end
  end

endmodule : iub_skid_buf
`default_nettype wire

// file: src/iub_bridge.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] While suspended with charging port seen, raise the charge-detect indication.
// [R2] Charge-detect appears on the configurable pin only when its function selects it.
// [R3] Charge-detect offered active-high or, by other selection, active-low.
// [R4] When not suspended (enumerated) the charge-detect stays inactive.
// [R5] Host bytes go to downstream buffer and out, in order, on slave reads.
// [R6] Master write bytes go to upstream buffer and on, in order, to host.
// [R7] Upstream data is released when the buffer fills or the latency timer expires.
// [R8] Device is only a slave; it never drives the serial clock.
// [R9] Host serial line settings have no effect on transfers.
// [R10] At each enumeration report the serial-layer option bit; cleared by default.
// [R11] Master should check data availability before trusting read data.
// [R12] Master should check upstream space before or while writing.
// [R13] Read address is not acknowledged while downstream buffer is empty; here it is still acked while a count or state reply is pending.
// [R14] Write address or data byte not acknowledged when no space remains.
// [R15] After general call 0x0C the next read returns the count, saturating at 0xFF.
// [R16] Active-low outputs: downstream holds data; upstream has a free byte.
// [R17] Charge-detect returns inactive on leaving suspend or losing the port.
// [R18] Latency timer restarts whenever upstream data has been sent.
module iub_bridge
  import iub_pkg::*;
#(
  parameter int unsigned LAT_CYCLES_P = LAT_CYCLES
)
(
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Serial bus, clock is input only
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic [6:0] slave_addr_i,
  // Host downstream bytes
  input wire logic dn_valid_i,
  input wire logic [7:0] dn_data_i,
  output logic dn_ready_o,
  // Host upstream bytes
  output logic up_valid_o,
  output logic [7:0] up_data_o,
  input wire logic up_ready_i,
  // Link state and configuration
  input wire logic suspended_i,
  input wire logic [1:0] usb_state_i,
  input wire logic dedicated_charge_port_i,
  input wire logic [1:0] pin_func_i,
  input wire logic other_func_i,
  input wire logic enumerate_i,
  input wire logic serial_layer_cfg_i,
  // Status outputs
  output logic configurable_io_pin_o,
  output logic serial_layer_opt_o,
  output logic downstream_data_present_n_o,
  output logic upstream_space_avail_n_o
);

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  // ========================================================
  // Serial engine state
  iub_st_t st_r, st_nxt;
  iub_reply_t rp_r, rp_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [7:0] sh_r, sh_nxt, tx_byte;
  logic rd_r, rd_nxt, gc_r, gc_nxt, ack_r, ack_nxt, oe_r, oe_nxt;
  logic scl_q, sda_q, scl_rise, scl_fall, start, stop;
  logic load_tx, dn_pop, up_push, flush;

  // ========================================================
  // Buffer state
  logic [7:0] dn_mem [FIFO_DEPTH];
  logic [7:0] up_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] dn_wp_r, dn_wp_nxt, dn_rp_r, dn_rp_nxt;
  logic [PTR_W-1:0] up_wp_r, up_wp_nxt, up_rp_r, up_rp_nxt;
  logic [CNT_W-1:0] dn_cnt_r, dn_cnt_nxt, up_cnt_r, up_cnt_nxt;
  logic [LAT_W-1:0] lat_r, lat_nxt;
  logic rel_r, rel_nxt, dn_push, up_pop, lat_exp;
  logic dn_rdy_r, dn_rdy_nxt, dp_n_r, dp_n_nxt, sp_n_r, sp_n_nxt;
  logic pin_r, pin_nxt, opt_r, opt_nxt, chg;

  iub_stream_if up_s ();
  iub_stream_if out_s ();

  // Bus edges; pins are taken as synchronous
  assign scl_rise = scl_i & ~scl_q;
  assign scl_fall = ~scl_i & scl_q;
  assign start = scl_i & scl_q & sda_q & ~sda_i;
  assign stop = scl_i & scl_q & ~sda_q & sda_i;

  // Byte offered on a read, chosen by the pending reply
  always_comb
  begin
    case (rp_r)
      RP_COUNT: tx_byte = iub_sat8(dn_cnt_r); // [R15]
      RP_STATE: tx_byte = {6'h00, usb_state_i};
      default: tx_byte = (dn_cnt_r != FIFO_EMPTY) ? dn_mem[dn_rp_r] : IDLE_BYTE; // [R11]
    endcase
  end

  // ========================================================
  // Serial engine next state; clock line is never driven [R8]
  always_comb
  begin
    st_nxt = st_r;
    rp_nxt = rp_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    rd_nxt = rd_r;
    gc_nxt = gc_r;
    ack_nxt = ack_r;
    oe_nxt = oe_r;
    load_tx = 1'b0;
    dn_pop = 1'b0;
    up_push = 1'b0;
    flush = 1'b0;
    if (stop)
    begin
      st_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end
    else if (start)
    begin
      st_nxt = ST_ADDR;
      bit_nxt = BIT_ZERO;
      oe_nxt = 1'b0;
    end
    else
    begin
      case (st_r)
        ST_IDLE: ;
        ST_ADDR, ST_RX:
          if (scl_rise)
          begin
            sh_nxt = {sh_r[6:0], sda_i};
            bit_nxt = bit_r + 4'h1;
          end
          else if (scl_fall && bit_r == BIT_BYTE)
          begin
            bit_nxt = BIT_ZERO;
            if (st_r == ST_ADDR)
            begin
              rd_nxt = sh_r[0];
              gc_nxt = (sh_r == GC_ADDR);
              if (sh_r[7:1] == slave_addr_i)
                ack_nxt = sh_r[0] ? (dn_cnt_r != FIFO_EMPTY || rp_r != RP_DATA) // [R13]
                                  : (up_cnt_r != FIFO_FULL); // [R14]
              else
                ack_nxt = gc_nxt;
              st_nxt = ST_AACK;
            end
            else
            begin
              if (gc_r)
              begin
                ack_nxt = 1'b1;
                case (sh_r)
                  CMD_DATA_AVAIL: rp_nxt = RP_COUNT; // [R15]
                  CMD_USB_STATE: rp_nxt = RP_STATE;
                  CMD_FLUSH, CMD_SOFT_RESET: flush = 1'b1;
                  default: ;
                endcase
              end
              else
              begin
                ack_nxt = (up_cnt_r != FIFO_FULL); // [R14]
                up_push = ack_nxt; // [R6]
              end
              st_nxt = ST_RACK;
            end
            oe_nxt = ack_nxt;
          end
        ST_AACK, ST_RACK:
          if (scl_fall)
          begin
            oe_nxt = 1'b0;
            if (!ack_r)
              st_nxt = ST_IDLE;
            else if (st_r == ST_AACK && rd_r)
              load_tx = 1'b1;
            else
              st_nxt = ST_RX;
          end
        ST_TX:
          if (scl_fall)
          begin
            bit_nxt = bit_r + 4'h1;
            if (bit_r == BIT_LAST)
            begin
              oe_nxt = 1'b0;
              st_nxt = ST_TACK;
            end
            else
            begin
              sh_nxt = {sh_r[6:0], 1'b1};
              oe_nxt = ~sh_r[6];
            end
          end
        ST_TACK:
          if (scl_rise)
            ack_nxt = ~sda_i;
          else if (scl_fall)
          begin
            if (ack_r)
              load_tx = 1'b1;
            else
              st_nxt = ST_IDLE;
          end
        default: st_nxt = ST_IDLE;
      endcase
    end
    // Next read byte: the pending count or state reply, else drawn in order from the downstream buffer, or 0xFF when it is empty
    if (load_tx)
    begin
      sh_nxt = tx_byte;
      oe_nxt = ~tx_byte[7];
      bit_nxt = BIT_ZERO;
      st_nxt = ST_TX;
      dn_pop = (rp_r == RP_DATA) && (dn_cnt_r != FIFO_EMPTY); // [R5]
      rp_nxt = RP_DATA;
    end
  end

  // Serial engine registers
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      st_r <= ST_IDLE;
      rp_r <= RP_DATA;
      bit_r <= BIT_ZERO;
      sh_r <= 8'h00;
      rd_r <= 1'b0;
      gc_r <= 1'b0;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      rp_r <= rp_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      rd_r <= rd_nxt;
      gc_r <= gc_nxt;
      ack_r <= ack_nxt;
      oe_r <= oe_nxt;
      scl_q <= scl_i;
      sda_q <= sda_i;
    end
  end

  // ========================================================
  // Buffers, release and latency timer
  assign dn_push = dn_valid_i & dn_rdy_r; // [R5]
  assign up_s.valid = rel_r & (up_cnt_r != FIFO_EMPTY);
  assign up_s.data = up_mem[up_rp_r];
  assign up_pop = up_s.valid & up_s.ready; // [R6]
  assign lat_exp = (lat_r == LAT_W'(LAT_CYCLES_P - 1));

  // Host line settings have no port here, so cannot steer transfers [R9]
  always_comb
  begin
    dn_wp_nxt = dn_wp_r + PTR_W'(dn_push);
    dn_rp_nxt = dn_rp_r + PTR_W'(dn_pop);
    dn_cnt_nxt = dn_cnt_r + CNT_W'(dn_push) - CNT_W'(dn_pop);
    up_wp_nxt = up_wp_r + PTR_W'(up_push);
    up_rp_nxt = up_rp_r + PTR_W'(up_pop);
    up_cnt_nxt = up_cnt_r + CNT_W'(up_push) - CNT_W'(up_pop);
    // Timer idles while empty or sending, so it restarts after each send
    lat_nxt = (rel_r || up_cnt_r == FIFO_EMPTY) ? '0 : lat_r + LAT_W'(1); // [R18]
    rel_nxt = rel_r;
    if (up_cnt_r == FIFO_FULL || (lat_exp && up_cnt_r != FIFO_EMPTY))
      rel_nxt = 1'b1; // [R7]
    else if (rel_r && up_cnt_nxt == FIFO_EMPTY)
      rel_nxt = 1'b0;
    if (flush)
    begin
      dn_wp_nxt = '0;
      dn_rp_nxt = '0;
      dn_cnt_nxt = FIFO_EMPTY;
      up_wp_nxt = '0;
      up_rp_nxt = '0;
      up_cnt_nxt = FIFO_EMPTY;
      rel_nxt = 1'b0;
      lat_nxt = '0;
    end
    dn_rdy_nxt = (dn_cnt_nxt != FIFO_FULL);
    dp_n_nxt = (dn_cnt_nxt == FIFO_EMPTY); // [R16]
    sp_n_nxt = (up_cnt_nxt == FIFO_FULL); // [R16]
  end

  // Storage writes; arrays hold no reset
  always_ff @(posedge mclk_i)
  begin
    if (dn_push)
      dn_mem[dn_wp_r] <= dn_data_i;
    if (up_push)
      up_mem[up_wp_r] <= sh_r;
  end

  // Buffer registers
  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      dn_wp_r <= '0;
      dn_rp_r <= '0;
      dn_cnt_r <= FIFO_EMPTY;
      up_wp_r <= '0;
      up_rp_r <= '0;
      up_cnt_r <= FIFO_EMPTY;
      lat_r <= '0;
      rel_r <= 1'b0;
      dn_rdy_r <= 1'b0;
      dp_n_r <= 1'b1;
      sp_n_r <= 1'b0;
    end
    else
    begin
      dn_wp_r <= dn_wp_nxt;
      dn_rp_r <= dn_rp_nxt;
      dn_cnt_r <= dn_cnt_nxt;
      up_wp_r <= up_wp_nxt;
      up_rp_r <= up_rp_nxt;
      up_cnt_r <= up_cnt_nxt;
      lat_r <= lat_nxt;
      rel_r <= rel_nxt;
      dn_rdy_r <= dn_rdy_nxt;
      dp_n_r <= dp_n_nxt;
      sp_n_r <= sp_n_nxt;
    end
  end

  // Skid stage so a host stall loses no byte
  iub_skid_buf u_skid (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .in_s(up_s),
    .out_s(out_s)
  );

  // ========================================================
  // Charge detect and configuration outputs
  assign chg = suspended_i & dedicated_charge_port_i; // [R1] [R4] [R17]

  always_comb
  begin
    case (pin_func_i)
      PF_CHG_HI: pin_nxt = chg; // [R2] [R3]
      PF_CHG_LO: pin_nxt = ~chg; // [R3]
      default: pin_nxt = other_func_i; // [R2]
    endcase
    opt_nxt = enumerate_i ? serial_layer_cfg_i : opt_r; // [R10]
  end

  always_ff @(posedge mclk_i)
  begin
    if (!reset_n_i)
    begin
      pin_r <= 1'b0;
      opt_r <= 1'b0;
    end
    else
    begin
      pin_r <= pin_nxt;
      opt_r <= opt_nxt;
    end
  end

  // Output drive; open drain only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = oe_r;
  assign dn_ready_o = dn_rdy_r;
  assign up_valid_o = out_s.valid;
  assign up_data_o = out_s.data;
  assign out_s.ready = up_ready_i;
  assign configurable_io_pin_o = pin_r;
  assign serial_layer_opt_o = opt_r;
  assign downstream_data_present_n_o = dp_n_r;
  assign upstream_space_avail_n_o = sp_n_r;

  // ========================================================
  // Checks
  a_charge_high_pol: assert property ((pin_func_i == PF_CHG_HI && chg) |=> pin_r) // [R1]
    else $error("charge detect not raised");
  a_charge_low_pol: assert property ((pin_func_i == PF_CHG_LO && chg) |=> !pin_r) // [R3]
    else $error("active-low charge detect not low");
  a_charge_inactive: assert property ((pin_func_i == PF_CHG_HI && !suspended_i) |=> !pin_r) // [R4]
    else $error("charge detect active while enumerated");
  a_pin_other_func: assert property ((pin_func_i == PF_OTHER) |=> pin_r == $past(other_func_i)) // [R2]
    else $error("pin not following other function");
  a_read_empty_nak: assert property ((st_r == ST_ADDR && scl_fall && !start && !stop // [R13]
    && bit_r == BIT_BYTE && sh_r[0] && dn_cnt_r == FIFO_EMPTY && rp_r == RP_DATA) |=> !oe_r)
    else $error("read acknowledged with empty buffer");
  // Host may drain in the same cycle, so check that no byte was stored
  a_write_full_nak: assert property ((st_r == ST_RX && scl_fall && !start && !stop // [R14]
    && bit_r == BIT_BYTE && !gc_r && up_cnt_r == FIFO_FULL)
    |=> !oe_r && up_wp_r == $past(up_wp_r))
    else $error("write acknowledged with full buffer");
  a_full_release: assert property ((up_cnt_r == FIFO_FULL && !flush) |=> rel_r) // [R7]
    else $error("full buffer not released");
  a_timer_release: assert property ((lat_exp && up_cnt_r != FIFO_EMPTY && !flush) |=> rel_r) // [R7]
    else $error("timer expiry did not release");
  a_timer_restart: assert property ($fell(rel_r) |-> lat_r == '0) // [R18]
    else $error("latency timer not restarted");
  a_status_pins: assert property (dp_n_r == (dn_cnt_r == FIFO_EMPTY) // [R16]
    && sp_n_r == (up_cnt_r == FIFO_FULL))
    else $error("status outputs disagree with buffers");
  a_enum_option: assert property (enumerate_i |=> opt_r == $past(serial_layer_cfg_i)) // [R10]
    else $error("option bit not reported at enumeration");

endmodule : iub_bridge
`default_nettype wire

// file: testbench/iub_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Serial bus master model, sole source of the bus clock
module iub_i2c_master
(
  // Clock
  input wire logic mclk_i,
  // Bus wires, released means high
  input wire logic sda_line_i,
  output var logic scl_o,
  output var logic sda_o
);
  // Bus idles released
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Half phase; 3 mclk, though 1 mclk is the shortest phase the slave takes
  task automatic hp();
    repeat (3) @(negedge mclk_i);
  endtask : hp

  // Bit slot from scl low; data moves only while scl is low
  task automatic slot(input logic b, output logic r);
    hp();
    sda_o = b;
    hp();
    scl_o = 1'b1;
    hp();
    r = sda_line_i;
    scl_o = 1'b0;
  endtask : slot

  // Start or repeated start, ends with scl low
  task automatic start_c();
    hp();
    sda_o = 1'b1;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b0;
    hp();
    scl_o = 1'b0;
  endtask : start_c

  // Stop, leaves the bus released
  task automatic stop_c();
    hp();
    sda_o = 1'b0;
    hp();
    scl_o = 1'b1;
    hp();
    sda_o = 1'b1;
    hp();
  endtask : stop_c

  // Byte out MSB first; ack is the slave pulling low
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      slot(d[i], r);
    slot(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  // Byte in MSB first, then our ack or nack
  task automatic rd_byte(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      slot(1'b1, r);
      d[i] = r;
    end
    slot(~ack, r);
  endtask : rd_byte
endmodule : iub_i2c_master
`default_nettype wire

// file: testbench/iub_bridge_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Self-checking bench for the bridge
module iub_bridge_test
  import iub_pkg::*;
();
  localparam int LAT = 50;
  localparam logic [6:0] ADDR = 7'h2A;
  localparam logic [7:0] RD = {ADDR, 1'b1};
  localparam logic [7:0] WR = {ADDR, 1'b0};
  // ========================================================
  // Signals
  logic mclk_i = 1'b0;
  logic reset_n_i, scl_w, m_sda, sda_w, sda_o, sda_oe_o, dn_valid_i, dn_ready_o;
  logic up_valid_o, up_ready_i, susp, dedicated_charge_port, oth, enum_p, cfg, pin, opt, pres_n, space_n;
  logic [7:0] dn_data_i, up_data_o;
  logic [1:0] pf;
  int failures = 0;
  int checks = 0;
  logic [7:0] up_q[$];
  logic [7:0] rq[$];

  // Clock; the data line is pulled up and only pulled low
  always #5 mclk_i = ~mclk_i;
  assign sda_w = m_sda & (sda_oe_o ? sda_o : 1'b1);
  // Host side taking upstream bytes
  always @(posedge mclk_i)
  begin
    if (up_valid_o === 1'b1 && up_ready_i === 1'b1)
      up_q.push_back(up_data_o);
  end

  iub_bridge #(.LAT_CYCLES_P(LAT)) dut_u (.mclk_i, .reset_n_i, .scl_i(scl_w), .sda_i(sda_w),
    .sda_o, .sda_oe_o, .slave_addr_i(ADDR), .dn_valid_i, .dn_data_i, .dn_ready_o,
    .up_valid_o, .up_data_o, .up_ready_i, .suspended_i(susp), .usb_state_i(2'h3),
    .dedicated_charge_port_i(dedicated_charge_port), .pin_func_i(pf), .other_func_i(oth), .enumerate_i(enum_p),
    .serial_layer_cfg_i(cfg), .configurable_io_pin_o(pin), .serial_layer_opt_o(opt),
    .downstream_data_present_n_o(pres_n), .upstream_space_avail_n_o(space_n));
  iub_i2c_master m_u (.mclk_i, .sda_line_i(sda_w), .scl_o(scl_w), .sda_o(m_sda));

  // ========================================================
  // Shared tasks
  task automatic close_out();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : tick

  // Host offers n bytes; a refused byte is held, not skipped
  task automatic push(input int n, output int taken);
    taken = 0;
    for (int i = 0; i < n; i++)
    begin
      @(negedge mclk_i);
      dn_valid_i = 1'b1;
      dn_data_i = taken[7:0];
      @(posedge mclk_i);
      if (dn_ready_o === 1'b1)
        taken++;
    end
    @(negedge mclk_i);
    dn_valid_i = 1'b0;
  endtask : push

  // Write stops at the first nack; n is bytes acked, -1 on address nack
  task automatic i2c_wr(input logic [7:0] a, input logic [7:0] b, input int cnt, output int n);
    logic ack;
    m_u.start_c();
    m_u.wr_byte(a, ack);
    n = ack ? 0 : -1;
    for (int i = 0; i < cnt && ack; i++)
    begin
      m_u.wr_byte(b + i[7:0], ack);
      n += ack ? 1 : 0;
    end
    m_u.stop_c();
  endtask : i2c_wr

  // Read only goes on once the address is acked
  task automatic i2c_rd(input int cnt, output logic aack);
    logic [7:0] d;
    rq.delete();
    m_u.start_c();
    m_u.wr_byte(RD, aack);
    for (int i = 0; i < cnt && aack; i++)
    begin
      m_u.rd_byte(i < cnt - 1, d);
      rq.push_back(d);
    end
    m_u.stop_c();
  endtask : i2c_rd

  task automatic gc(input logic [7:0] cmd);
    int n;
    i2c_wr(GC_ADDR, cmd, 1, n);
  endtask : gc

  // Bounded wait for the host to hold n bytes
  task automatic wait_up(input int n, input int bound);
    for (int i = 0; i < bound && up_q.size() < n; i++)
      @(negedge mclk_i);
    chk("up bytes", n[15:0], 16'(up_q.size()));
    if (up_q.size() < n)
      close_out();
  endtask : wait_up

  // ========================================================
  // Scenarios
  task automatic t_reset();
    logic a;
    chk("present_n", 16'h1, pres_n);
    chk("space_n", 16'h0, space_n);
    chk("option", 16'h0, opt);
    i2c_rd(1, a);
    chk("empty read ack", 16'h0, a);
    $display("reset test done");
  endtask : t_reset

  // Every pin function against suspend, port and other value
  task automatic t_charge();
    logic e;
    for (int f = 0; f < 4; f++)
      for (int k = 0; k < 8; k++)
      begin
        pf = f[1:0];
        {susp, dedicated_charge_port, oth} = k[2:0];
        tick(2);
        e = (f == 1) ? (k[2] & k[1]) : (f == 2) ? ~(k[2] & k[1]) : k[0];
        chk("pin", e, pin);
      end
    $display("charge test done");
  endtask : t_charge

  // Option follows the config bit only at enumeration
  task automatic t_option();
    for (int k = 0; k < 2; k++)
    begin
      cfg = ~k[0];
      enum_p = 1'b1;
      tick(1);
      enum_p = 1'b0;
      cfg = k[0];
      tick(2);
      chk("option", {15'h0000, ~k[0]}, opt);
    end
    $display("option test done");
  endtask : t_option

  task automatic t_down();
    int n;
    logic a;
    push(4, n);
    chk("present_n", 16'h0, pres_n);
    gc(CMD_DATA_AVAIL);
    i2c_rd(1, a);
    chk("count", 16'h4, rq[0]);
    i2c_rd(4, a);
    for (int i = 0; i < 4; i++)
      chk("down byte", i[15:0], rq[i]);
    i2c_rd(1, a);
    chk("empty read ack", 16'h0, a);
    chk("present_n", 16'h1, pres_n);
    // A pending reply is still served with the buffer empty
    gc(CMD_DATA_AVAIL);
    i2c_rd(1, a);
    chk("count ack", 16'h1, a);
    chk("count", 16'h0, rq[0]);
    gc(CMD_USB_STATE);
    i2c_rd(1, a);
    chk("usb state", 16'h3, rq[0]);
    $display("downstream test done");
  endtask : t_down

  // Fill until refused, saturated count, then both clearing commands
  task automatic t_fill();
    int n;
    logic a;
    push(600, n);
    chk("taken", 16'(FIFO_DEPTH), n[15:0]);
    chk("dn_ready", 16'h0, dn_ready_o);
    gc(CMD_DATA_AVAIL);
    i2c_rd(1, a);
    chk("count", 16'h00FF, rq[0]);
    i2c_rd(3, a);
    for (int i = 0; i < 3; i++)
      chk("down byte", i[15:0], rq[i]);
    for (int k = 0; k < 2; k++)
    begin
      if (k == 1)
        push(2, n);
      gc(k == 1 ? CMD_SOFT_RESET : CMD_FLUSH);
      tick(2);
      chk("present_n", 16'h1, pres_n);
      i2c_rd(1, a);
      chk("empty read ack", 16'h0, a);
    end
    $display("fill test done");
  endtask : t_fill

  // Partial buffers leave on the timer, which restarts after each release
  task automatic t_up();
    int n;
    up_ready_i = 1'b1;
    up_q.delete();
    i2c_wr(WR, 8'h40, 3, n);
    chk("acked", 16'h3, n[15:0]);
    wait_up(3, LAT + 30);
    for (int i = 0; i < 3; i++)
      chk("up byte", 16'h40 + i[15:0], up_q[i]);
    i2c_wr(WR, 8'h50, 1, n);
    wait_up(4, LAT + 30);
    chk("up byte", 16'h50, up_q[3]);
    $display("upstream test done");
  endtask : t_up

  // Host stalls: write until nacked, then drain with nothing lost
  task automatic t_full();
    int n;
    int m;
    up_ready_i = 1'b0;
    up_q.delete();
    i2c_wr(WR, 8'h00, 600, m);
    chk("space_n", 16'h1, space_n);
    chk("accepted", 16'h1, m >= FIFO_DEPTH && m <= FIFO_DEPTH + 2);
    i2c_wr(WR, 8'h00, 1, n);
    chk("addr nack", 16'hFFFF, n[15:0]);
    up_ready_i = 1'b1;
    wait_up(m, m + 300);
    for (int i = 0; i < m; i++)
      chk("up byte", {8'h00, i[7:0]}, up_q[i]);
    chk("space_n", 16'h0, space_n);
    $display("full test done");
  endtask : t_full

  // ========================================================
  // Main sequence
  initial
  begin
    reset_n_i = 1'b0;
    {dn_valid_i, up_ready_i, susp, dedicated_charge_port, oth, enum_p, cfg} = 7'h00;
    dn_data_i = 8'h00;
    pf = 2'h0;
    tick(12);
    reset_n_i = 1'b1;
    tick(2);
    t_reset();
    t_charge();
    t_option();
    t_down();
    t_fill();
    t_up();
    t_full();
    close_out();
  end
endmodule : iub_bridge_test
`default_nettype wire
